// *** core/angle_sensor_diag_status_regs.sv ***
/*
 * Diagnostic and status register bank of the angle sensor: latched error
 * and warning flags with read-then-clear, readouts, angle views, unlock.
 * Assumes: the serial front end gives one-cycle rd_stb/wr_stb with a byte
 * address of a 16-bit location; condition inputs are synchronous pulses
 * or levels from the processing chain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "diag_regs_map.svh"

// Notes on behaviour
// - digital undervoltage bit, re-sets while present
// - latch oscillator, pll-lock and self-test errors
// - uncorrectable memory read sets bit 5
// - missing zero crossing sets bit 6
// - quadrature integrity loss sets bit 8
// - averaging corruption sets bit 9
// - bit 11 summarises unmasked warnings, maskable
// - field above upper threshold sets warning 1
// - overlapping extended access sets warning 2
// - any internal saturation sets warning 4
// - corrected memory error sets warning 5
// - temperature out of range warns and clamps
// - failed extended command sets warning 7
// - slew limiting acting sets warning 8
// - bad frame warning 11, checksum warning 10
// - temperature eighths signed, field in gauss
// - hysteresis angle 12 bits, fine angle 15
// - crossing detector angle, same scaling
// - bit 12 makes word parity odd
// - bit 13 live masked undervoltage
// - bit 14 any unmasked flag set
// - five-code unlock, keycode reads zero
// - error bits 2 to 10 stay latched until cleared
// - error clear only removes bits read
// - warning clear only removes bits read
module angle_sensor_diag_status_regs (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register access from the serial front end
    input wire logic rd_stb,
    input wire logic wr_stb,
    input wire diag_regs_pkg::addr_t addr,
    input wire diag_regs_pkg::word_t wr_data,
    output diag_regs_pkg::word_t rd_data,
    output logic rd_valid,
    // fault conditions
    input wire logic uv_analog,
    input wire logic uv_digital,
    input wire logic osc_trip,
    input wire logic ecc_uncorr,
    input wire logic zc_timeout,
    input wire logic pll_unlock,
    input wire logic quad_fault,
    input wire logic avg_fault,
    input wire logic selftest_fail,
    // warning conditions
    input wire logic ext_start,
    input wire logic ext_busy,
    input wire logic sat_any,
    input wire logic ecc_corr,
    input wire logic ext_cmd_fail,
    input wire logic slew_enable,
    input wire logic slew_needed,
    input wire logic frame_bad,
    input wire logic frame_chk_bad,
    // measurements
    input wire logic [11:0] temp_raw,
    input wire logic [11:0] field_gauss,
    input wire logic [11:0] field_upper_threshold,
    input wire logic [11:0] hyst_angle,
    input wire logic [14:0] fine_angle,
    input wire logic [11:0] zcd_angle,
    // shadow mask, a set bit hides the flag
    input wire logic [15:0] err_mask,
    input wire logic [15:0] warn_mask,
    // status
    output logic any_fault_flag,
    output logic live_undervoltage_flag,
    output logic temp_range_warning,
    output logic unlocked
);
    import diag_regs_pkg::*;

    word_t err_ff, nxt_err;
    word_t warn_ff, nxt_warn;
    word_t err_seen_ff, nxt_err_seen;
    word_t warn_seen_ff, nxt_warn_seen;
    word_t rd_data_ff, nxt_rd_data;
    logic rd_valid_ff;
    logic [11:0] temp_ff, nxt_temp;
    logic fault_ff, uvl_ff, trange_ff;
    word_t err_set, warn_set, err_view;
    logic temp_low, temp_high, fault_now, uvl_now, key_wr, war_now;
    logic unlocked_int;

    // angle view word with parity, undervoltage and fault bits
    // odd parity bit
    function automatic word_t make_view(input logic [11:0] ang, input logic u,
                                        input logic f);
        word_t w;
        w = {1'b0, f, u, 1'b0, ang};
        w[`VIEW_PAR] = ~(^w);
        return w;
    endfunction : make_view

    function automatic logic hit(input addr_t ofs);
        return addr == ofs;
    endfunction : hit

    assign temp_low = $signed(temp_raw) < $signed(`TEMP_MIN);
    assign temp_high = $signed(temp_raw) > $signed(`TEMP_MAX);

    assign uvl_now = (uv_analog & ~err_mask[`ERR_UVA]) | (uv_digital & ~err_mask[`ERR_UVD]);

    // warning summary, forced low by its mask
    assign war_now = (|(warn_ff & ~warn_mask & `WARN_USED)) & ~err_mask[`ERR_WAR];

    always_comb begin
        err_set = `REG_RST;
        // level input re-sets each cycle after a clear
        err_set[`ERR_UVA] = uv_analog;
        err_set[`ERR_UVD] = uv_digital;
        err_set[`ERR_OSC] = osc_trip;
        err_set[`ERR_PLL] = pll_unlock;
        err_set[`ERR_STF] = selftest_fail;
        err_set[`ERR_ECC] = ecc_uncorr;
        err_set[`ERR_ZCI] = zc_timeout;
        err_set[`ERR_QUAD] = quad_fault;
        err_set[`ERR_AVG] = avg_fault;
        warn_set = `REG_RST;
        warn_set[`WARN_FHI] = field_gauss > field_upper_threshold;
        warn_set[`WARN_BUSY] = ext_start & ext_busy;
        warn_set[`WARN_SAT] = sat_any;
        warn_set[`WARN_SOFT] = ecc_corr;
        warn_set[`WARN_TEMP] = temp_low | temp_high;
        warn_set[`WARN_XCMD] = ext_cmd_fail;
        warn_set[`WARN_SLEW] = slew_enable & slew_needed;
        warn_set[`WARN_FRM] = frame_bad;
        warn_set[`WARN_CHK] = frame_chk_bad;
    end

    // the error word as read includes the live summary bit
    always_comb begin
        err_view = err_ff;
        err_view[`ERR_WAR] = war_now;
    end

    assign fault_now = (|(err_view & ~err_mask)) | (|(warn_ff & ~warn_mask));

    always_comb begin
        nxt_err = err_ff;
        nxt_warn = warn_ff;
        nxt_err_seen = err_seen_ff;
        nxt_warn_seen = warn_seen_ff;
        // remember which set bits the host has seen; a read snapshot
        if (rd_stb && hit(`OFS_ERR)) begin
            nxt_err_seen = err_ff;
        end
        if (rd_stb && hit(`OFS_WARN)) begin
            nxt_warn_seen = warn_ff;
        end
        if (wr_stb && hit(`OFS_CTRL)) begin
            if (wr_data[`CTRL_CLR_ERR]) begin
                nxt_err = err_ff & ~err_seen_ff;
                nxt_err_seen = `REG_RST;
            end
            if (wr_data[`CTRL_CLR_WARN]) begin
                nxt_warn = warn_ff & ~warn_seen_ff;
                nxt_warn_seen = `REG_RST;
            end
        end
        // latched; a new event wins over a clear
        nxt_err = (nxt_err | err_set) & `ERR_USED;
        nxt_err[`ERR_WAR] = 1'b0;
        nxt_warn = (nxt_warn | warn_set) & `WARN_USED;
    end

    always_comb begin
        nxt_temp = temp_raw;
        if (temp_low) begin
            nxt_temp = `TEMP_MIN;
        end else if (temp_high) begin
            nxt_temp = `TEMP_MAX;
        end
    end

    always_comb begin
        nxt_rd_data = `REG_RST;
        // unassigned bits and addresses read zero
        unique case (addr)
            `OFS_ERR: nxt_rd_data = err_view;
            `OFS_WARN: nxt_rd_data = warn_ff;
            `OFS_TEMP: nxt_rd_data = {4'h0, temp_ff};
            `OFS_FIELD: nxt_rd_data = {4'h0, field_gauss};
            `OFS_HANG: nxt_rd_data = make_view(hyst_angle, uvl_ff, fault_ff);
            `OFS_FANG: nxt_rd_data = {1'b0, fine_angle};
            `OFS_ZCD_VIEW: nxt_rd_data = make_view(zcd_angle, uvl_ff, fault_ff);
            `OFS_KEY: nxt_rd_data = {15'h0000, unlocked_int};
            default: nxt_rd_data = `REG_RST;
        endcase
        if (!rd_stb) begin
            nxt_rd_data = rd_data_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            err_ff <= `REG_RST;
            warn_ff <= `REG_RST;
            err_seen_ff <= `REG_RST;
            warn_seen_ff <= `REG_RST;
            rd_data_ff <= `REG_RST;
            rd_valid_ff <= 1'b0;
            temp_ff <= 12'h000;
            fault_ff <= 1'b0;
            uvl_ff <= 1'b0;
            trange_ff <= 1'b0;
        end else begin
            err_ff <= nxt_err;
            warn_ff <= nxt_warn;
            err_seen_ff <= nxt_err_seen;
            warn_seen_ff <= nxt_warn_seen;
            rd_data_ff <= nxt_rd_data;
            rd_valid_ff <= rd_stb;
            temp_ff <= nxt_temp;
            fault_ff <= fault_now;
            uvl_ff <= uvl_now;
            trange_ff <= warn_ff[`WARN_TEMP];
        end
    end

    assign key_wr = wr_stb && hit(`OFS_KEY);

    key_unlock u_key (
        .clk(clk),
        .rst_n(rst_n),
        .wr_stb(key_wr),
        .wr_code(wr_data[`KEY_HI:`KEY_LO]),
        .unlocked(unlocked_int)
    );

    assign rd_data = rd_data_ff;
    assign rd_valid = rd_valid_ff;
    assign any_fault_flag = fault_ff;
    assign live_undervoltage_flag = uvl_ff;
    assign temp_range_warning = trange_ff;
    assign unlocked = unlocked_int;

    a_uvd_resets: assert property (@(posedge clk) disable iff (!rst_n)
        uv_digital |=> err_ff[`ERR_UVD])
        else $error("digital undervoltage not latched");
    a_err_latched: assert property (@(posedge clk) disable iff (!rst_n)
        (err_ff[`ERR_OSC] && !(wr_stb && hit(`OFS_CTRL))) |=> err_ff[`ERR_OSC])
        else $error("error bit lost without clear");
    a_clear_unread: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_stb && hit(`OFS_CTRL) && wr_data[`CTRL_CLR_ERR] && err_ff[`ERR_STF]
         && !err_seen_ff[`ERR_STF]) |=> err_ff[`ERR_STF])
        else $error("unread error cleared");
    a_clear_read: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_stb && hit(`OFS_CTRL) && wr_data[`CTRL_CLR_WARN] && warn_seen_ff[`WARN_SAT]
         && !sat_any) |=> !warn_ff[`WARN_SAT])
        else $error("read warning not cleared");
    a_busy_warn: assert property (@(posedge clk) disable iff (!rst_n)
        (ext_start && ext_busy) |=> warn_ff[`WARN_BUSY])
        else $error("overlap warning missing");
    a_view_parity: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_valid_ff && $past(addr) == `OFS_HANG) |-> ^rd_data_ff)
        else $error("angle view parity even");
    a_temp_clamp: assert property (@(posedge clk) disable iff (!rst_n)
        temp_high |=> temp_ff == `TEMP_MAX && warn_ff[`WARN_TEMP])
        else $error("temperature not clamped");
    a_frame_warn: assert property (@(posedge clk) disable iff (!rst_n)
        frame_bad |=> warn_ff[`WARN_FRM])
        else $error("frame warning missing");
    a_key_reads0: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_valid_ff && $past(addr) == `OFS_KEY) |-> rd_data_ff[15:1] == 15'h0000)
        else $error("keycode reads nonzero");
    a_temp_floor: assert property (@(posedge clk) disable iff (!rst_n)
        temp_low |=> temp_ff == `TEMP_MIN && warn_ff[`WARN_TEMP])
        else $error("temperature floor not clamped");
    a_soft_warn: assert property (@(posedge clk) disable iff (!rst_n)
        ecc_corr |=> warn_ff[`WARN_SOFT])
        else $error("soft error warning missing");
    a_chk_warn: assert property (@(posedge clk) disable iff (!rst_n)
        frame_chk_bad |=> warn_ff[`WARN_CHK])
        else $error("checksum warning missing");
    a_slew_warn: assert property (@(posedge clk) disable iff (!rst_n)
        (slew_enable && slew_needed) |=> warn_ff[`WARN_SLEW])
        else $error("slew warning missing");
    a_sum_masked: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_valid_ff && $past(addr) == `OFS_ERR && $past(err_mask[`ERR_WAR]))
        |-> !rd_data_ff[`ERR_WAR])
        else $error("masked summary read as set");
    a_field_warn: assert property (@(posedge clk) disable iff (!rst_n)
        (field_gauss > field_upper_threshold) |=> warn_ff[`WARN_FHI])
        else $error("field warning missing");
    a_unused_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_valid_ff && $past(addr) == `OFS_WARN) |-> (rd_data_ff & ~`WARN_USED) == 16'h0000)
        else $error("unassigned warning bit set");
    a_pll_latch: assert property (@(posedge clk) disable iff (!rst_n)
        pll_unlock |=> err_ff[`ERR_PLL])
        else $error("lock loss not latched");

    c_err_clear: cover property (@(posedge clk)
        wr_stb && hit(`OFS_CTRL) && wr_data[`CTRL_CLR_ERR] && |err_seen_ff);
    c_unlock: cover property (@(posedge clk) $rose(unlocked_int));
    c_view_read: cover property (@(posedge clk) rd_stb && hit(`OFS_ZCD_VIEW) && fault_ff);
    c_temp_clamp: cover property (@(posedge clk) temp_low);
endmodule : angle_sensor_diag_status_regs
`default_nettype wire

// *** shared/diag_regs_map.svh ***
/*
 * Register offsets, field positions, reset values and constants of the
 * diagnostic and status register bank.
 * Assumes: included by its bare name; byte addresses of 16-bit locations.
 */
`ifndef DIAG_REGS_MAP_SVH
`define DIAG_REGS_MAP_SVH

`define OFS_CTRL 8'h1E
`define OFS_ERR 8'h24
`define OFS_WARN 8'h26
`define OFS_TEMP 8'h28
`define OFS_FIELD 8'h2A
`define OFS_HANG 8'h30
`define OFS_FANG 8'h32
`define OFS_ZCD_VIEW 8'h34
`define OFS_KEY 8'h3C

`define CTRL_CLR_ERR 8
`define CTRL_CLR_WARN 9

`define ERR_UVA 2
`define ERR_UVD 3
`define ERR_OSC 4
`define ERR_ECC 5
`define ERR_ZCI 6
`define ERR_PLL 7
`define ERR_QUAD 8
`define ERR_AVG 9
`define ERR_STF 10
`define ERR_WAR 11
`define ERR_USED 16'h0FFF

`define WARN_FHI 1
`define WARN_BUSY 2
`define WARN_SAT 4
`define WARN_SOFT 5
`define WARN_TEMP 6
`define WARN_XCMD 7
`define WARN_SLEW 8
`define WARN_CHK 10
`define WARN_FRM 11
`define WARN_USED 16'h0DF6

`define VIEW_PAR 12
`define VIEW_UVL 13
`define VIEW_FLT 14

`define KEY_UNLOCK 0
`define KEY_LO 8
`define KEY_HI 15
`define KEY_C0 8'h00
`define KEY_C1 8'h27
`define KEY_C2 8'h81
`define KEY_C3 8'h1F
`define KEY_C4 8'h77

// minus 60 degrees is 85 degrees below the 25 degree origin, in eighths
`define TEMP_MIN 12'hD58
`define TEMP_MAX 12'h4D8
`define REG_RST 16'h0000

`endif

// *** shared/diag_regs_pkg.sv ***
/*
 * Types shared by the diagnostic register bank.
 * Assumes: constants come from diag_regs_map.svh.
 */
package diag_regs_pkg;
    typedef logic [15:0] word_t;
    typedef logic [7:0] addr_t;
    typedef enum logic [2:0] {
        KEY_IDLE,
        KEY_GOT0,
        KEY_GOT1,
        KEY_GOT2,
        KEY_GOT3
    } key_step_e;
endpackage : diag_regs_pkg

// *** core/key_unlock.sv ***
/*
 * Customer unlock keycode sequencer: five writes in order set unlocked.
 * Assumes: wr_stb is one cycle per host write to the key location.
 */
`timescale 1ns/1ps
`default_nettype none
`include "diag_regs_map.svh"

module key_unlock (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // keycode write
    input wire logic wr_stb,
    input wire logic [7:0] wr_code,
    // state
    output logic unlocked
);
    import diag_regs_pkg::*;

    key_step_e step_ff;
    key_step_e nxt_step;
    logic unlocked_ff;
    logic nxt_unlocked;

    always_comb begin
        nxt_step = step_ff;
        nxt_unlocked = unlocked_ff;
        if (wr_stb) begin
            // a wrong code restarts, but a fresh 0x00 may begin a new try
            nxt_step = (wr_code == `KEY_C0) ? KEY_GOT0 : KEY_IDLE;
            unique case (step_ff)
                KEY_IDLE: ;
                KEY_GOT0: if (wr_code == `KEY_C1) nxt_step = KEY_GOT1;
                KEY_GOT1: if (wr_code == `KEY_C2) nxt_step = KEY_GOT2;
                KEY_GOT2: if (wr_code == `KEY_C3) nxt_step = KEY_GOT3;
                KEY_GOT3: begin
                    if (wr_code == `KEY_C4) begin
                        nxt_unlocked = 1'b1;
                        nxt_step = KEY_IDLE;
                    end
                end
                default: nxt_step = KEY_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            step_ff <= KEY_IDLE;
            unlocked_ff <= 1'b0;
        end else begin
            step_ff <= nxt_step;
            unlocked_ff <= nxt_unlocked;
        end
    end

    assign unlocked = unlocked_ff;

    a_key_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        unlocked_ff |=> unlocked_ff)
        else $error("unlock bit dropped");
endmodule : key_unlock
`default_nettype wire

// *** sim/spi_host_model.sv ***
/* Host stand-in for the serial front end: one-cycle read or write strobes.
   Assumes: the bank takes a strobe on the rising clk edge it sees high. */
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    // clock
    input wire logic clk,
    // register access
    output logic rd_stb,
    output logic wr_stb,
    output diag_regs_pkg::addr_t addr,
    output diag_regs_pkg::word_t wr_data
);
    import diag_regs_pkg::*;
    initial begin
        rd_stb = 1'b0;
        wr_stb = 1'b0;
        addr = 8'h00;
        wr_data = 16'h0000;
    end
    task automatic acc(input logic w, input addr_t a, input word_t d);
        @(posedge clk);
        #1;
        rd_stb = ~w;
        wr_stb = w;
        addr = a;
        wr_data = d;
        @(posedge clk);
        #1;
        rd_stb = 1'b0;
        wr_stb = 1'b0;
        // released lines show the inverse so a stale value cannot pass
        addr = ~a;
        wr_data = ~d;
    endtask : acc
endmodule : spi_host_model
`default_nettype wire

// *** sim/angle_sensor_diag_status_regs_test.sv ***
/* Self-checking bench of the diagnostic and status register bank.
   Assumes: host model drives strobes; read data answers one cycle later. */
`timescale 1ns/1ps
`default_nettype none
module angle_sensor_diag_status_regs_test;
    import diag_regs_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic rd_stb, wr_stb, rd_valid, ext_busy, slew_enable;
    addr_t addr;
    word_t wr_data, rd_data, err_mask, warn_mask;
    logic [10:0] ev_e;
    logic [11:0] ev_w, temp_raw, field_gauss, thr, hyst, zcd;
    logic [14:0] fine;
    logic any_fault_flag, live_uvl, trw, unlocked;
    word_t exp_q[$];
    int n_fail = 0;
    int n_checks = 0;
    int seed = 33922;
    addr_t ra[10] = '{8'h24, 8'h26, 8'h28, 8'h2A, 8'h30, 8'h32, 8'h34, 8'h3C, 8'h1E, 8'h2C};
    word_t re[10] = '{0, 0, 0, 0, 16'h1000, 0, 16'h1000, 0, 0, 0};
    int wb[7] = '{2, 4, 5, 7, 8, 10, 11};
    logic [7:0] kc[8] = '{8'h00, 8'h27, 8'h55, 8'h00, 8'h27, 8'h81, 8'h1F, 8'h77};

    always #2 clk = ~clk;

    spi_host_model host_u (.clk(clk), .rd_stb(rd_stb), .wr_stb(wr_stb), .addr(addr),
        .wr_data(wr_data));
    angle_sensor_diag_status_regs dut_u (.clk(clk), .rst_n(rst_n), .rd_stb(rd_stb),
        .wr_stb(wr_stb), .addr(addr), .wr_data(wr_data), .rd_data(rd_data),
        .rd_valid(rd_valid), .uv_analog(ev_e[2]), .uv_digital(ev_e[3]), .osc_trip(ev_e[4]),
        .ecc_uncorr(ev_e[5]), .zc_timeout(ev_e[6]), .pll_unlock(ev_e[7]),
        .quad_fault(ev_e[8]), .avg_fault(ev_e[9]), .selftest_fail(ev_e[10]),
        .ext_start(ev_w[2]), .ext_busy(ext_busy), .sat_any(ev_w[4]), .ecc_corr(ev_w[5]),
        .ext_cmd_fail(ev_w[7]), .slew_enable(slew_enable), .slew_needed(ev_w[8]),
        .frame_bad(ev_w[11]), .frame_chk_bad(ev_w[10]), .temp_raw(temp_raw),
        .field_gauss(field_gauss), .field_upper_threshold(thr), .hyst_angle(hyst),
        .fine_angle(fine), .zcd_angle(zcd), .err_mask(err_mask), .warn_mask(warn_mask),
        .any_fault_flag(any_fault_flag), .live_undervoltage_flag(live_uvl),
        .temp_range_warning(trw), .unlocked(unlocked));

    task automatic chk(input word_t seen, input word_t exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_sim;
        $display("checks=%0d fails=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    task automatic rd(input addr_t a, input word_t e);
        exp_q.push_back(e);
        host_u.acc(1'b0, a, 16'h0000);
    endtask : rd

    task automatic wr(input addr_t a, input word_t d);
        host_u.acc(1'b1, a, d);
    endtask : wr

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : idle

    task automatic pulse(input logic w, input int b);
        idle(1);
        if (w) ev_w[b] = 1'b1;
        else ev_e[b] = 1'b1;
        idle(1);
        ev_w = '0;
        ev_e = '0;
    endtask : pulse

    function automatic word_t view(input logic [11:0] a, input logic u, input logic f);
        return {1'b0, f, u, ~^{f, u, a}, a};
    endfunction : view

    // each answer is paired with the oldest note
    always @(posedge clk) begin
        if (rd_valid === 1'b1) begin
            chk(rd_data, (exp_q.size() > 0) ? exp_q.pop_front() : ~rd_data);
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        end_sim();
    end

    initial begin
        ev_e = '0;
        ev_w = '0;
        ext_busy = 1'b0;
        slew_enable = 1'b0;
        temp_raw = 12'h000;
        field_gauss = 12'h000;
        thr = 12'hFFF;
        hyst = 12'h000;
        zcd = 12'h000;
        fine = 15'h0000;
        err_mask = 16'h0000;
        warn_mask = 16'h0000;
        idle(20);
        rst_n = 1'b1;
        for (int i = 0; i < 10; i++) rd(ra[i], re[i]);
        wr(8'h24, 16'hFFFF);
        wr(8'h30, 16'hFFFF);
        rd(8'h24, 16'h0000);
        rd(8'h30, 16'h1000);
        for (int b = 2; b <= 10; b++) begin
            pulse(1'b0, b);
            idle(3);
            rd(8'h24, 16'h0001 << b);
            wr(8'h1E, 16'h0100);
            rd(8'h24, 16'h0000);
        end
        pulse(1'b1, 2);
        pulse(1'b1, 8);
        rd(8'h26, 16'h0000);
        ext_busy = 1'b1;
        slew_enable = 1'b1;
        foreach (wb[i]) begin
            pulse(1'b1, wb[i]);
            rd(8'h26, 16'h0001 << wb[i]);
            rd(8'h24, 16'h0800);
            wr(8'h1E, 16'h0200);
            rd(8'h26, 16'h0000);
            rd(8'h24, 16'h0000);
        end
        ext_busy = 1'b0;
        slew_enable = 1'b0;
        pulse(1'b0, 4);
        rd(8'h24, 16'h0010);
        pulse(1'b0, 7);
        wr(8'h1E, 16'h0100);
        rd(8'h24, 16'h0080);
        wr(8'h1E, 16'h0100);
        ev_e[3] = 1'b1;
        idle(2);
        chk(16'(live_uvl), 16'h0001);
        rd(8'h24, 16'h0008);
        wr(8'h1E, 16'h0100);
        rd(8'h24, 16'h0008);
        ev_e[3] = 1'b0;
        wr(8'h1E, 16'h0100);
        rd(8'h24, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            hyst = 12'($random(seed));
            zcd = 12'($random(seed));
            fine = 15'($random(seed));
            ev_e[2] = (i == 1 || i == 2);
            err_mask = (i == 1) ? 16'h0004 : 16'h0000;
            idle(3);
            rd(8'h30, view(hyst, i == 2, i >= 2));
            rd(8'h34, view(zcd, i == 2, i >= 2));
            rd(8'h32, {1'b0, fine});
            chk(16'(live_uvl), 16'(i == 2));
            chk(16'(any_fault_flag), 16'(i >= 2));
        end
        rd(8'h24, 16'h0004);
        wr(8'h1E, 16'h0100);
        // clamp at 180 and at minus 60 degrees
        temp_raw = 12'h7FF;
        idle(3);
        rd(8'h28, 16'h04D8);
        chk(16'(trw), 16'h0001);
        temp_raw = 12'h800;
        idle(2);
        rd(8'h28, 16'h0D58);
        temp_raw = 12'h4D8;
        idle(2);
        rd(8'h26, 16'h0040);
        wr(8'h1E, 16'h0200);
        rd(8'h26, 16'h0000);
        temp_raw = 12'hD57;
        idle(2);
        rd(8'h26, 16'h0040);
        temp_raw = 12'h123;
        wr(8'h1E, 16'h0200);
        rd(8'h28, 16'h0123);
        chk(16'(trw), 16'h0000);
        thr = 12'($random(seed)) & 12'h7FF;
        field_gauss = thr;
        idle(2);
        rd(8'h2A, {4'h0, thr});
        rd(8'h26, 16'h0000);
        field_gauss = thr + 12'h001;
        idle(2);
        rd(8'h26, 16'h0002);
        err_mask = 16'h0800;
        idle(2);
        rd(8'h24, 16'h0000);
        err_mask = 16'h0000;
        warn_mask = 16'h0002;
        idle(2);
        rd(8'h24, 16'h0000);
        chk(16'(any_fault_flag), 16'h0000);
        warn_mask = 16'h0000;
        field_gauss = 12'h000;
        wr(8'h1E, 16'h0200);
        rd(8'h26, 16'h0000);
        foreach (kc[i]) begin
            if (i == 3) chk(16'(unlocked), 16'h0000);
            wr(8'h3C, {kc[i], 8'h00});
        end
        idle(2);
        chk(16'(unlocked), 16'h0001);
        rd(8'h3C, 16'h0001);
        idle(4);
        chk(16'(exp_q.size()), 16'h0000);
        end_sim();
    end
endmodule : angle_sensor_diag_status_regs_test
`default_nettype wire
